// ---- logic/pssd_sram.sv ----
// Cycle decode, burst counter, byte-lane writes and data pin control of the SRAM
`timescale 1ns/100ps
`include "pssd_consts.svh"

module pssd_sram #(
  parameter int ADDR_W  = `PSSD_ADDR_W,
  parameter int DATA_W  = `PSSD_DATA_W,
  parameter int LANES   = `PSSD_LANES,
  parameter int LANE_W  = `PSSD_LANE_W,
  parameter int BURST_W = `PSSD_BURST_W
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  // Synchronous address and controls
  input  wire logic [ADDR_W-1:0] addr_i,
  input  pssd_pkg::pssd_ctrl_t   ctrl_i,
  input  wire logic              burst_order_i,
  // Asynchronous controls
  input  wire logic              output_enable_n_i,
  input  wire logic              sleep_request_i,
  // Common data pins
  input  wire logic [DATA_W-1:0] dq_i,
  output logic      [DATA_W-1:0] dq_o,
  output logic                   dq_oe_o,
  // Status
  output pssd_pkg::pssd_cyc_t    cycle_o,
  output logic                   sleep_o
);

  logic [DATA_W-1:0]  mem [0:(2**ADDR_W)-1];

  pssd_pkg::pssd_slp_t slp_r;
  pssd_pkg::pssd_cyc_t cyc_nxt;
  pssd_pkg::pssd_cyc_t cyc_r;

  logic [ADDR_W-1:BURST_W] base_hi_r;
  logic [BURST_W-1:0]      base_lo_r;
  logic [BURST_W-1:0]      cnt_r;
  logic [BURST_W-1:0]      cnt_nxt;
  logic                    active_r;
  logic                    active_nxt;

  logic [ADDR_W-1:0]  use_addr;
  logic [LANES-1:0]   lanes;
  logic               wr_req;
  logic               sel_all;
  logic               desel;
  logic               hold;
  logic               asleep;
  logic               wr_now;
  logic               rd_now;
  logic               new_base;

  logic [ADDR_W-1:0]  rd_addr_r;
  logic               rd_pend_r;
  logic               rd_valid_r;
  logic               wr_cyc_r;
  logic [DATA_W-1:0]  dq_r;

  // Burst address low bits for a given step count
  function automatic logic [BURST_W-1:0] burst_lo(
    input logic [BURST_W-1:0] base,
    input logic [BURST_W-1:0] cnt,
    input logic               interleaved
  );
    if (interleaved)
    begin
      burst_lo = base ^ cnt;
    end
    else
    begin
      burst_lo = base + cnt;
    end
  endfunction

  // Lanes to write from the write inputs
  always_comb
  begin
    if (!ctrl_i.global_write_n)
    begin
      lanes = {LANES{1'b1}};
    end
    else if (!ctrl_i.byte_write_gate_n)
    begin
      lanes = ~ctrl_i.lane_write_n;
    end
    else
    begin
      lanes = {LANES{1'b0}};
    end
  end

  assign wr_req = |lanes;

  assign sel_all = !ctrl_i.chip_sel_first_n && ctrl_i.chip_sel_second &&
                   !ctrl_i.chip_sel_third_n;

  // First select off leaves the processor strobe a don't-care, so the burst carries on
  assign desel = (!ctrl_i.controller_addr_strobe_n && ctrl_i.chip_sel_first_n) ||
                 (!ctrl_i.chip_sel_first_n &&
                  (!ctrl_i.processor_addr_strobe_n || !ctrl_i.controller_addr_strobe_n) &&
                  (!ctrl_i.chip_sel_second || ctrl_i.chip_sel_third_n));

  // Neither strobe is accepted: the burst continues or suspends
  assign hold = ctrl_i.controller_addr_strobe_n &&
                (ctrl_i.processor_addr_strobe_n || ctrl_i.chip_sel_first_n);

  // Request acts at once; the state machine keeps the block idle through recovery
  assign asleep = sleep_request_i || (slp_r != pssd_pkg::PSSD_SLP_AWAKE);

  // Next cycle type, burst count and address used
  always_comb
  begin
    cyc_nxt    = pssd_pkg::PSSD_CYC_DESEL;
    cnt_nxt    = cnt_r;
    active_nxt = active_r;
    use_addr   = {base_hi_r, burst_lo(base_lo_r, cnt_r, burst_order_i)};
    if (asleep)
    begin
      cyc_nxt    = pssd_pkg::PSSD_CYC_SLEEP;
      active_nxt = 1'b0;
    end
    else if (desel)
    begin
      cyc_nxt    = pssd_pkg::PSSD_CYC_DESEL;
      active_nxt = 1'b0;
    end
    else if (sel_all && !ctrl_i.processor_addr_strobe_n)
    begin
      cyc_nxt    = pssd_pkg::PSSD_CYC_BEGIN_RD;
      cnt_nxt    = `PSSD_CNT_ZERO;
      active_nxt = 1'b1;
      use_addr   = addr_i;
    end
    else if (sel_all && !ctrl_i.controller_addr_strobe_n)
    begin
      cyc_nxt    = wr_req ? pssd_pkg::PSSD_CYC_BEGIN_WR
                          : pssd_pkg::PSSD_CYC_BEGIN_RD;
      cnt_nxt    = `PSSD_CNT_ZERO;
      active_nxt = 1'b1;
      use_addr   = addr_i;
    end
    else if (hold && active_r)
    begin
      if (!ctrl_i.burst_advance_n)
      begin
        cnt_nxt  = cnt_r + 1'b1;
        use_addr = {base_hi_r, burst_lo(base_lo_r, cnt_nxt, burst_order_i)};
        cyc_nxt  = wr_req ? pssd_pkg::PSSD_CYC_CONT_WR
                          : pssd_pkg::PSSD_CYC_CONT_RD;
      end
      else
      begin
        cyc_nxt  = wr_req ? pssd_pkg::PSSD_CYC_SUSP_WR
                          : pssd_pkg::PSSD_CYC_SUSP_RD;
      end
    end
  end

  // Writes are legal only when the cycle type says so
  function automatic logic is_wr(input pssd_pkg::pssd_cyc_t c);
    is_wr = (c == pssd_pkg::PSSD_CYC_BEGIN_WR) || (c == pssd_pkg::PSSD_CYC_CONT_WR) ||
            (c == pssd_pkg::PSSD_CYC_SUSP_WR);
  endfunction

  function automatic logic is_rd(input pssd_pkg::pssd_cyc_t c);
    is_rd = (c == pssd_pkg::PSSD_CYC_BEGIN_RD) || (c == pssd_pkg::PSSD_CYC_CONT_RD) ||
            (c == pssd_pkg::PSSD_CYC_SUSP_RD);
  endfunction

  assign wr_now   = is_wr(cyc_nxt);
  assign rd_now   = is_rd(cyc_nxt);
  assign new_base = (cyc_nxt == pssd_pkg::PSSD_CYC_BEGIN_RD) ||
                    (cyc_nxt == pssd_pkg::PSSD_CYC_BEGIN_WR);

  // Sleep sequencing: two clocks to enter and two to leave
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      slp_r <= pssd_pkg::PSSD_SLP_AWAKE;
    end
    else
    begin
      unique case (slp_r)
        pssd_pkg::PSSD_SLP_AWAKE:
          if (sleep_request_i)
          begin
            slp_r <= pssd_pkg::PSSD_SLP_ENTER;
          end
        // A request dropped during entry goes straight on to the exit half
        pssd_pkg::PSSD_SLP_ENTER:
          slp_r <= sleep_request_i ? pssd_pkg::PSSD_SLP_ASLEEP
                                   : pssd_pkg::PSSD_SLP_EXIT;
        pssd_pkg::PSSD_SLP_ASLEEP:
          if (!sleep_request_i)
          begin
            slp_r <= pssd_pkg::PSSD_SLP_EXIT;
          end
        pssd_pkg::PSSD_SLP_EXIT:
          slp_r <= sleep_request_i ? pssd_pkg::PSSD_SLP_ENTER
                                   : pssd_pkg::PSSD_SLP_AWAKE;
      endcase
    end
  end

  // Address register and burst counter
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      base_hi_r <= '0;
      base_lo_r <= `PSSD_CNT_ZERO;
      cnt_r     <= `PSSD_CNT_ZERO;
      active_r  <= 1'b0;
      cyc_r     <= pssd_pkg::PSSD_CYC_DESEL;
    end
    else
    begin
      if (new_base)
      begin
        base_hi_r <= addr_i[ADDR_W-1:BURST_W];
        base_lo_r <= addr_i[BURST_W-1:0];
      end
      cnt_r    <= cnt_nxt;
      active_r <= active_nxt;
      cyc_r    <= cyc_nxt;
    end
  end

  // Array write, with data sampled on the same edge as the write controls
  always_ff @(posedge clk_i)
  begin
    if (wr_now)
    begin
      for (int i = 0; i < LANES; i++)
      begin
        if (lanes[i])
        begin
          mem[use_addr][i*LANE_W +: LANE_W] <= dq_i[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  // Read pipeline: address registered, then data registered one edge later
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rd_addr_r  <= '0;
      rd_pend_r  <= 1'b0;
      rd_valid_r <= 1'b0;
      wr_cyc_r   <= 1'b0;
      dq_r       <= '0;
    end
    else
    begin
      rd_pend_r <= rd_now;
      wr_cyc_r  <= wr_now;
      if (rd_now)
      begin
        rd_addr_r <= use_addr;
      end
      if (rd_pend_r && !asleep)
      begin
        dq_r <= mem[rd_addr_r];
      end
      // A read followed by deselect, a write or sleep never reaches the pins
      rd_valid_r <= rd_pend_r && !asleep && !wr_now &&
                    (cyc_nxt != pssd_pkg::PSSD_CYC_DESEL);
    end
  end

  // Output enable acts without the clock and is masked in write cycles
  assign dq_oe_o = rd_valid_r && !wr_cyc_r && !output_enable_n_i &&
                   !asleep;
  assign dq_o    = dq_r;
  assign cycle_o = cyc_r;
  assign sleep_o = (slp_r == pssd_pkg::PSSD_SLP_ASLEEP);

endmodule

// ---- logic/pssd_consts.svh ----
// Constants for the pipelined synchronous SRAM cycle decoder
`ifndef PSSD_CONSTS_SVH
`define PSSD_CONSTS_SVH
`define PSSD_ADDR_W   18
`define PSSD_DATA_W   32
`define PSSD_LANES    4
`define PSSD_LANE_W   8
`define PSSD_BURST_W  2
`define PSSD_CNT_ZERO 2'h0
`endif

// ---- logic/pssd_pkg.sv ----
// Types shared by the pipelined synchronous SRAM cycle decoder
`include "pssd_consts.svh"
package pssd_pkg;

  // Synchronous controls sampled on the rising clock edge, all as pin levels
  typedef struct packed {
    logic                     chip_sel_first_n;
    logic                     chip_sel_second;
    logic                     chip_sel_third_n;
    logic                     processor_addr_strobe_n;
    logic                     controller_addr_strobe_n;
    logic                     burst_advance_n;
    logic                     global_write_n;
    logic                     byte_write_gate_n;
    logic [`PSSD_LANES-1:0]   lane_write_n;
  } pssd_ctrl_t;

  typedef enum logic [2:0] {
    PSSD_CYC_DESEL,
    PSSD_CYC_BEGIN_RD,
    PSSD_CYC_BEGIN_WR,
    PSSD_CYC_CONT_RD,
    PSSD_CYC_SUSP_RD,
    PSSD_CYC_CONT_WR,
    PSSD_CYC_SUSP_WR,
    PSSD_CYC_SLEEP
  } pssd_cyc_t;

  typedef enum logic [1:0] {
    PSSD_SLP_AWAKE,
    PSSD_SLP_ENTER,
    PSSD_SLP_ASLEEP,
    PSSD_SLP_EXIT
  } pssd_slp_t;

endpackage

// ---- sim/pssd_host_model.sv ----
// Bus controller model driving the write data lines
`timescale 1ns/100ps
module pssd_host_model (
  // Clock
  input  wire logic        clk_i,
  // Write data request
  input  wire logic        drive_i,
  input  wire logic [31:0] data_i,
  // Data lines seen by the SRAM
  output logic      [31:0] dq_o
);
  logic [31:0] last_r = 32'h0;
  always_ff @(posedge clk_i)
    last_r <= dq_o;
  // Released lines show the inverse of the last value
  assign dq_o = drive_i ? data_i : ~last_r;
endmodule

// ---- sim/pssd_sram_monitor.sv ----
// Checker of cycle decode, sleep and data pin control
`timescale 1ns/100ps
module pssd_sram_monitor (
  // Clock and reset
  input wire logic            clk_i,
  input wire logic            nrst_i,
  // Watched inputs
  input pssd_pkg::pssd_ctrl_t ctrl_i,
  input wire logic            output_enable_n_i,
  input wire logic            sleep_request_i,
  // Watched outputs
  input wire logic            dq_oe_o,
  input pssd_pkg::pssd_cyc_t  cycle_o,
  input wire logic            sleep_o
);
  logic [1:0] awake_r;
  wire sel = !ctrl_i.chip_sel_first_n && ctrl_i.chip_sel_second && !ctrl_i.chip_sel_third_n;
  wire ps  = ctrl_i.processor_addr_strobe_n;
  wire cs  = ctrl_i.controller_addr_strobe_n;
  wire go  = awake_r == 2'h3 && !sleep_request_i;
  wire rd  = cycle_o inside {pssd_pkg::PSSD_CYC_BEGIN_RD, pssd_pkg::PSSD_CYC_CONT_RD,
                             pssd_pkg::PSSD_CYC_SUSP_RD};
  // Decode checks wait out the sleep recovery
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
      awake_r <= 2'h0;
    else
      awake_r <= sleep_request_i ? 2'h0 : (awake_r == 2'h3 ? 2'h3 : awake_r + 2'h1);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  a_oe_float: assert property (output_enable_n_i |-> !dq_oe_o)
    else $error("data driven while output enable high");
  a_sleep_float: assert property (sleep_request_i |-> !dq_oe_o)
    else $error("data driven while sleep requested");
  a_nonread_float: assert property (!rd |-> !dq_oe_o)
    else $error("data driven outside a read");
  a_proc_read: assert property (go && sel && !ps |=>
    cycle_o == pssd_pkg::PSSD_CYC_BEGIN_RD) else $error("processor strobe not a read");
  a_desel_first: assert property (go && !cs && ctrl_i.chip_sel_first_n |=>
    cycle_o == pssd_pkg::PSSD_CYC_DESEL) else $error("first select off not deselect");
  a_ctrl_write: assert property (go && sel && ps && !cs && !ctrl_i.global_write_n |=>
    cycle_o == pssd_pkg::PSSD_CYC_BEGIN_WR) else $error("controller write missed");
  a_burst_step: assert property (go && rd && ps && cs && ctrl_i.global_write_n
    && ctrl_i.byte_write_gate_n |=> cycle_o == ($past(ctrl_i.burst_advance_n) ?
    pssd_pkg::PSSD_CYC_SUSP_RD : pssd_pkg::PSSD_CYC_CONT_RD)) else $error("burst step wrong");
  a_sleep_entry: assert property ($rose(sleep_request_i) ##1 sleep_request_i |=> sleep_o)
    else $error("sleep not reached in two clocks");
  a_sleep_cycle: assert property (sleep_request_i |=> cycle_o == pssd_pkg::PSSD_CYC_SLEEP)
    else $error("sleep cycle not decoded");
endmodule
bind pssd_sram pssd_sram_monitor u_mon (.clk_i(clk_i), .nrst_i(nrst_i), .ctrl_i(ctrl_i),
  .output_enable_n_i(output_enable_n_i), .sleep_request_i(sleep_request_i),
  .dq_oe_o(dq_oe_o), .cycle_o(cycle_o), .sleep_o(sleep_o));

// ---- sim/tb_top.sv ----
// Self-checking bench for the SRAM cycle decoder
`timescale 1ns/100ps
module tb_top;
  typedef struct packed {logic [3:0] ln; logic [31:0] rd; pssd_pkg::pssd_cyc_t cy;} pssd_row_t;
  logic                 clk_i = 0, nrst_i = 0, oe_n = 1, slp = 0, drv = 0, ord = 1;
  logic [17:0]          addr = 18'h0;
  logic [31:0]          wd = 32'h0, dq_i, dq_o;
  logic                 dq_oe, sleep;
  pssd_pkg::pssd_ctrl_t ctrl = 12'hBFF;
  pssd_pkg::pssd_cyc_t  cyc;
  int                   num_errors = 0, n_checks = 0;
  pssd_row_t rows [4] = '{'{4'hE, 32'h000000FF, pssd_pkg::PSSD_CYC_BEGIN_WR},
    '{4'hA, 32'h00FF00FF, pssd_pkg::PSSD_CYC_BEGIN_WR},
    '{4'h0, 32'hFFFFFFFF, pssd_pkg::PSSD_CYC_BEGIN_WR},
    '{4'hF, 32'h0, pssd_pkg::PSSD_CYC_BEGIN_RD}};
  always #12.5 clk_i = ~clk_i;
  pssd_host_model u_host (.clk_i(clk_i), .drive_i(drv), .data_i(wd), .dq_o(dq_i));
  pssd_sram DUT (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr), .ctrl_i(ctrl),
    .burst_order_i(ord), .output_enable_n_i(oe_n), .sleep_request_i(slp), .dq_i(dq_i),
    .dq_o(dq_o), .dq_oe_o(dq_oe), .cycle_o(cyc), .sleep_o(sleep));
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      num_errors++;
    end
  endtask
  // One clock of stimulus, entered and left at the falling edge
  task step(input logic [11:0] c, input logic [17:0] a, input logic [31:0] d);
    ctrl = c;
    addr = a;
    wd = d;
    drv = c[8] && (!c[5] || (!c[4] && c[3:0] != 4'hF));
    if (drv)
      oe_n = 1;
    @(negedge clk_i);
  endtask
  task final_report;
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #100000;
    num_errors++;
    final_report;
  end
  initial
  begin
    repeat (16) @(negedge clk_i);
    chk("cyc_rst", pssd_pkg::PSSD_CYC_DESEL, cyc);
    chk("oe_rst", 0, dq_oe);
    chk("dq_rst", 0, dq_o);
    chk("slp_rst", 0, sleep);
    nrst_i = 1;
    @(negedge clk_i);
    foreach (rows[i])
    begin
      step(12'h55F, 18'h0, 32'h0);
      step({8'h56, rows[i].ln}, 18'h0, 32'hFFFFFFFF);
      chk("cycle", rows[i].cy, cyc);
      oe_n = 0;
      step(12'h4DF, 18'h0, 32'h0);
      step(12'hBFF, 18'h0, 32'h0);
      chk("read", rows[i].rd, dq_o);
      chk("oe_on", 1, dq_oe);
      oe_n = 1;
      #1;
      chk("oe_off", 0, dq_oe);
    end
    // Write started by the processor strobe, data on the second clock
    step(12'h4FF, 18'h8, 32'h0);
    step(12'hBDF, 18'h0, 32'hA5A5A5A5);
    step(12'h4FF, 18'h8, 32'h0);
    step(12'hBFF, 18'h0, 32'h0);
    chk("proc_wr", 32'hA5A5A5A5, dq_o);
    // Write burst stepped on by advance, then read back with first select off
    step(12'h55F, 18'hC, 32'h11111111);
    step(12'hB9F, 18'h0, 32'h22222222);
    chk("cont_wr", pssd_pkg::PSSD_CYC_CONT_WR, cyc);
    oe_n = 0;
    step(12'h4DF, 18'hD, 32'h0);
    step(12'h8FF, 18'h0, 32'h0);
    chk("ce1_off", pssd_pkg::PSSD_CYC_SUSP_RD, cyc);
    chk("cont_wr_rd", 32'h22222222, dq_o);
    // Reset in mid-run drops the active burst
    nrst_i = 0;
    #1;
    chk("cyc_rst2", pssd_pkg::PSSD_CYC_DESEL, cyc);
    chk("oe_rst2", 0, dq_oe);
    @(negedge clk_i);
    nrst_i = 1;
    step(12'hBFF, 18'h0, 32'h0);
    chk("rst_idle", pssd_pkg::PSSD_CYC_DESEL, cyc);
    for (int o = 0; o < 2; o++)
    begin
      ord = o[0];
      for (int k = 0; k < 4; k++)
        step(12'h55F, 18'h4 + k[17:0], k);
      oe_n = 0;
      step(12'h4DF, 18'h5, 32'h0);
      for (int k = 0; k < 4; k++)
      begin
        step(k < 3 ? 12'hBBF : 12'hB7F, 18'h0, 32'h0);
        chk("burst", o ? (1 ^ k) : ((1 + k) & 3), dq_o);
      end
      chk("desel", pssd_pkg::PSSD_CYC_DESEL, cyc);
      chk("desel_oe", 0, dq_oe);
    end
    slp = 1;
    step(12'hBFF, 18'h0, 32'h0);
    step(12'hBFF, 18'h0, 32'h0);
    chk("asleep", 1, sleep);
    chk("slp_oe", 0, dq_oe);
    slp = 0;
    repeat (3) step(12'hBFF, 18'h0, 32'h0);
    chk("awake", 0, sleep);
    final_report;
  end
endmodule
